// ### design/rtcr_pkg.sv
// Package of the real-time counter register block: register indices,
// field positions, reset values and carrier types.
// Assumes a byte-wide register map reached as one 32-bit word per index.
package rtcr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W = 5;
  localparam int unsigned ADDR_W = 7;
  localparam logic [IDX_W-1:0] IDX_CTRL = 5'h00;
  localparam logic [IDX_W-1:0] IDX_STAT = 5'h01;
  localparam logic [IDX_W-1:0] IDX_IEN = 5'h02;
  localparam logic [IDX_W-1:0] IDX_IFLG = 5'h03;
  localparam logic [IDX_W-1:0] IDX_LATCH = 5'h04;
  localparam logic [IDX_W-1:0] IDX_HALT = 5'h05;
  localparam logic [IDX_W-1:0] IDX_TRIM = 5'h06;
  localparam logic [IDX_W-1:0] IDX_SRC = 5'h07;
  localparam logic [IDX_W-1:0] IDX_CNT_L = 5'h08;
  localparam logic [IDX_W-1:0] IDX_CNT_H = 5'h09;
  localparam logic [IDX_W-1:0] IDX_LIM_L = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_LIM_H = 5'h0B;
  localparam logic [IDX_W-1:0] IDX_MAT_L = 5'h0C;
  localparam logic [IDX_W-1:0] IDX_MAT_H = 5'h0D;
  localparam logic [IDX_W-1:0] IDX_TCTL = 5'h10;
  localparam logic [IDX_W-1:0] IDX_TSTAT = 5'h11;
  localparam logic [IDX_W-1:0] IDX_TIEN = 5'h12;
  localparam logic [IDX_W-1:0] IDX_TIFL = 5'h13;
  localparam logic [IDX_W-1:0] IDX_THALT = 5'h15;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FLG_WRAP = 0;
  localparam int unsigned FLG_MATCH = 1;
  localparam int unsigned TCTL_EN = 0;
  localparam int unsigned TRIM_SIGN = 7;
  // Sync channels; the first four are the status bit positions
  localparam int unsigned SY_CTRL = 0;
  localparam int unsigned SY_CNT = 1;
  localparam int unsigned SY_LIM = 2;
  localparam int unsigned SY_MAT = 3;
  localparam int unsigned SY_TICK = 4;
  localparam int unsigned SY_N = 5;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_LIMIT = 16'hFFFF;
  localparam logic [15:0] RST_MATCH = 16'h0000;
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  localparam int unsigned CAL_SPAN_DEF = 1000000;
  localparam int unsigned PRE_W = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic keep_running_asleep;
    logic [3:0] prescale;
    logic drift_fix_enable;
    logic rsvd;
    logic counter_enable;
  } rtcr_ctrl_t;

  typedef struct packed {
    logic [6:0] rsvd;
    logic [1:0] resp;
    logic [7:0] data;
  } rtcr_rd_t;

endpackage : rtcr_pkg

// ### design/rtcr_top.sv
// Real-time counter register block with AXI4-Lite slave, prescaler,
// drift correction, 16-bit counter with wrap and match interrupts.
// Assumes i_cnt_tick is a one-cycle enable marking each counter clock
// edge, synchronous to i_mclk, and i_standby is a synchronous level.
//
// Behaviour
// - Prescaler divides counter clock by two to the power of code.
// - New control takes effect two counter clocks after the write.
// - Bit 7 set keeps counter running in standby, else it stops.
// - Bit 2 turns drift correction of the prescaler on or off.
// - Bit 0 starts the counter when set, stops it when clear.
// - Status bits show pending match, limit, count, control sync.
// - Enable bit 1 lets the match flag raise the interrupt.
// - Enable bit 0 lets the wrap flag raise the interrupt.
// - Match flag sets when the count equals the match value.
// - Count reaching the wrap limit returns to zero, sets wrap flag.
// - Writing one clears a flag; writing zero leaves it alone.
// - One shared byte latch serves all 16-bit registers, readable.
// - Interrupt stays high while an enabled flag remains set.
// - Prescaler runs if counter runs or tick timer is enabled.
// - Tick status shows a busy flag while tick control syncs.
// - Counting runs on the counter clock, apart from the bus.
`timescale 1ns/1ps
module rtcr_top
  import rtcr_pkg::*;
#(
  parameter int unsigned CAL_SPAN = CAL_SPAN_DEF
)(
  input wire logic i_mclk,                  // Bus clock, 20 MHz
  input wire logic i_rst_b,                 // Async reset, active low
  input wire logic i_cnt_tick,              // Counter clock enable
  input wire logic i_standby,               // Standby sleep level
  input wire logic i_awvalid,               // AXI write address valid
  output logic o_awready,                   // AXI write address ready
  input wire logic [ADDR_W-1:0] i_awaddr,   // AXI write address
  input wire logic [2:0] i_awprot,          // AXI write prot, unused
  input wire logic i_wvalid,                // AXI write data valid
  output logic o_wready,                    // AXI write data ready
  input wire logic [31:0] i_wdata,          // AXI write data
  input wire logic [3:0] i_wstrb,           // AXI write strobes
  output logic o_bvalid,                    // AXI write response valid
  input wire logic i_bready,                // AXI write response ready
  output logic [1:0] o_bresp,               // AXI write response
  input wire logic i_arvalid,               // AXI read address valid
  output logic o_arready,                   // AXI read address ready
  input wire logic [ADDR_W-1:0] i_araddr,   // AXI read address
  input wire logic [2:0] i_arprot,          // AXI read prot, unused
  output logic o_rvalid,                    // AXI read data valid
  input wire logic i_rready,                // AXI read data ready
  output logic [31:0] o_rdata,              // AXI read data
  output logic [1:0] o_rresp,               // AXI read response
  output logic o_irq,                       // Interrupt, level, high
  output logic o_wrap_evt,                  // Wrap event pulse
  output logic o_match_evt,                 // Match event pulse
  output logic [1:0] o_clk_source           // Counter clock source sel
);

  localparam int unsigned CAL_W = $clog2(CAL_SPAN);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CAL_SPAN < 256 || CAL_SPAN > 1048576)
  begin : g_bad_span
    $error("CAL_SPAN out of range");
  end

  function automatic logic idx_ok(input logic [IDX_W-1:0] idx);
    idx_ok = (idx <= IDX_MAT_H) ||
             ((idx >= IDX_TCTL) && (idx <= IDX_THALT) && (idx != 5'h14));
  endfunction : idx_ok

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rtcr_ctrl_t ctrl_q;
  rtcr_ctrl_t ctrl_act_q;
  logic [7:0] tctl_q;
  logic [7:0] tctl_act_q;
  logic [1:0] ien_q;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic [7:0] latch_q;
  logic [7:0] halt_q;
  logic [7:0] trim_q;
  logic [1:0] src_q;
  logic tien_q;
  logic thalt_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_new_q;
  logic [15:0] lim_q;
  logic [15:0] lim_act_q;
  logic [15:0] mat_q;
  logic [15:0] mat_act_q;
  logic [SY_N-1:0] pend_q;
  logic [1:0] stage_q [SY_N];
  logic [SY_N-1:0] sy_start;
  logic [SY_N-1:0] sy_apply;
  logic [PRE_W-1:0] pre_q;
  logic [CAL_W-1:0] cal_span_q;
  logic [6:0] cal_left_q;
  logic aw_held_q;
  logic w_held_q;
  logic [IDX_W-1:0] aw_idx_q;
  logic aw_bad_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_go;
  logic wr_en;
  logic rd_go;
  logic [IDX_W-1:0] ar_idx;
  rtcr_rd_t rd;
  logic cnt_run;
  logic pre_run;
  logic [PRE_W-1:0] pre_inc;
  logic [PRE_W-1:0] pre_nx;
  logic [PRE_W-1:0] pre_mask;
  logic pre_pulse;
  logic [15:0] cnt_nx;
  logic wrap_hit;
  logic match_hit;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response after both
  assign wr_go = aw_held_q && w_held_q && !o_bvalid;
  assign wr_en = wr_go && !aw_bad_q && wlane_q;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= IDX_CTRL;
      aw_bad_q <= 1'b0;
      wbyte_q <= RST_BYTE;
      wlane_q <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else
    begin
      if (o_awready && i_awvalid)
      begin
        o_awready <= 1'b0;
        aw_held_q <= 1'b1;
        aw_idx_q <= i_awaddr[ADDR_W-1:2];
        aw_bad_q <= (i_awaddr[1:0] != 2'h0) ||
                    !idx_ok(i_awaddr[ADDR_W-1:2]);
      end
      if (o_wready && i_wvalid)
      begin
        o_wready <= 1'b0;
        w_held_q <= 1'b1;
        wbyte_q <= i_wdata[7:0];
        wlane_q <= i_wstrb[0];
      end
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= aw_bad_q ? RESP_SLVERR : RESP_OKAY;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_go = o_arready && i_arvalid;
  assign ar_idx = i_araddr[ADDR_W-1:2];

  always_comb
  begin
    rd = '0;
    rd.resp = RESP_OKAY;
    case (ar_idx)
      IDX_CTRL: rd.data = ctrl_q;
      IDX_STAT: rd.data = {4'h0, pend_q[SY_MAT:SY_CTRL]};
      IDX_IEN: rd.data = {6'h00, ien_q};
      IDX_IFLG: rd.data = {6'h00, flags_q};
      IDX_LATCH: rd.data = latch_q;
      IDX_HALT: rd.data = {7'h00, halt_q[0]};
      IDX_TRIM: rd.data = trim_q;
      IDX_SRC: rd.data = {6'h00, src_q};
      IDX_CNT_L: rd.data = cnt_q[7:0];
      IDX_LIM_L: rd.data = lim_q[7:0];
      IDX_MAT_L: rd.data = mat_q[7:0];
      // high byte comes from the latch
      IDX_CNT_H, IDX_LIM_H, IDX_MAT_H: rd.data = latch_q;
      IDX_TCTL: rd.data = tctl_q;
      IDX_TSTAT: rd.data = {7'h00, pend_q[SY_TICK]};
      IDX_TIEN: rd.data = {7'h00, tien_q};
      IDX_TIFL: rd.data = 8'h00;
      IDX_THALT: rd.data = {7'h00, thalt_q};
      default: rd.resp = RESP_SLVERR;
    endcase
    if (i_araddr[1:0] != 2'h0)
    begin
      rd.data = 8'h00;
      rd.resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= {24'h000000, rd.data};
      o_rresp <= rd.resp;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shared byte latch
  // ----------------------------------------------------------------
  // Reads and writes of the latch share one register, so an interrupt
  // handler doing 16-bit access must save and restore it
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      latch_q <= RST_BYTE;
    else if (wr_en && (aw_idx_q == IDX_LATCH || aw_idx_q == IDX_CNT_L ||
             aw_idx_q == IDX_LIM_L || aw_idx_q == IDX_MAT_L))
      latch_q <= wbyte_q;
    else if (rd_go && i_araddr[1:0] == 2'h0)
    begin
      case (ar_idx)
        IDX_CNT_L: latch_q <= cnt_q[15:8];
        IDX_LIM_L: latch_q <= lim_q[15:8];
        IDX_MAT_L: latch_q <= mat_q[15:8];
        default: latch_q <= latch_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Plain configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctrl_q <= RST_BYTE;
      tctl_q <= RST_BYTE;
      ien_q <= 2'h0;
      halt_q <= RST_BYTE;
      trim_q <= RST_BYTE;
      src_q <= 2'h0;
      tien_q <= 1'b0;
      thalt_q <= 1'b0;
      o_clk_source <= 2'h0;
    end
    else
    begin
      o_clk_source <= src_q;
      if (wr_en)
      begin
        case (aw_idx_q)
          IDX_CTRL: ctrl_q <= {wbyte_q[7:2], 1'b0, wbyte_q[0]};
          IDX_TCTL: tctl_q <= {1'b0, wbyte_q[6:3], 2'h0, wbyte_q[0]};
          IDX_IEN: ien_q <= wbyte_q[1:0];
          IDX_HALT: halt_q <= {7'h00, wbyte_q[0]};
          IDX_TRIM: trim_q <= wbyte_q;
          IDX_SRC: src_q <= wbyte_q[1:0];
          IDX_TIEN: tien_q <= wbyte_q[0];
          IDX_THALT: thalt_q <= wbyte_q[0];
          default: src_q <= src_q;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // 16-bit bus-side values
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_new_q <= RST_COUNT;
      lim_q <= RST_LIMIT;
      mat_q <= RST_MATCH;
    end
    else if (wr_en)
    begin
      case (aw_idx_q)
        IDX_CNT_H: cnt_new_q <= {wbyte_q, latch_q};
        IDX_LIM_H: lim_q <= {wbyte_q, latch_q};
        IDX_MAT_H: mat_q <= {wbyte_q, latch_q};
        default: lim_q <= lim_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transfer into the counter clock domain
  // ----------------------------------------------------------------
  always_comb
  begin
    sy_start = '0;
    if (wr_en)
    begin
      sy_start[SY_CTRL] = (aw_idx_q == IDX_CTRL);
      sy_start[SY_CNT] = (aw_idx_q == IDX_CNT_H);
      sy_start[SY_LIM] = (aw_idx_q == IDX_LIM_H);
      sy_start[SY_MAT] = (aw_idx_q == IDX_MAT_H);
      sy_start[SY_TICK] = (aw_idx_q == IDX_TCTL);
    end
  end

  // A rewrite while pending restarts the count; software that ignores
  // the busy flag only delays the update, it never corrupts it
  // rewrite before busy clears
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pend_q <= '0;
      for (int i = 0; i < SY_N; i++)
        stage_q[i] <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < SY_N; i++)
      begin
        if (sy_start[i])
        begin
          pend_q[i] <= 1'b1;
          stage_q[i] <= 2'h0;
        end
        else if (sy_apply[i])
          pend_q[i] <= 1'b0;
        else if (pend_q[i] && i_cnt_tick)
          stage_q[i] <= stage_q[i] + 2'h1;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < SY_N; i++)
      sy_apply[i] = pend_q[i] && i_cnt_tick && !sy_start[i] &&
                    (stage_q[i] == SYNC_TICKS - 2'h1);
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctrl_act_q <= RST_BYTE;
      tctl_act_q <= RST_BYTE;
      lim_act_q <= RST_LIMIT;
      mat_act_q <= RST_MATCH;
    end
    else
    begin
      if (sy_apply[SY_CTRL])
        ctrl_act_q <= ctrl_q;
      if (sy_apply[SY_TICK])
        tctl_act_q <= tctl_q;
      if (sy_apply[SY_LIM])
        lim_act_q <= lim_q;
      if (sy_apply[SY_MAT])
        mat_act_q <= mat_q;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler with drift correction
  // ----------------------------------------------------------------
  // counter run gate
  assign cnt_run = ctrl_act_q.counter_enable &&
                   (!i_standby || ctrl_act_q.keep_running_asleep);
  assign pre_run = cnt_run || tctl_act_q[TCTL_EN];
  // divide by two to the code
  assign pre_mask = PRE_W'((16'h0001 << ctrl_act_q.prescale) - 16'h0001);

  // correction holds or doubles a step
  always_comb
  begin
    pre_inc = PRE_W'(1);
    if (cal_left_q != 7'h00)
      pre_inc = trim_q[TRIM_SIGN] ? PRE_W'(2) : PRE_W'(0);
  end

  assign pre_nx = pre_q + pre_inc;
  assign pre_pulse = pre_run && i_cnt_tick && (pre_inc != '0) &&
                     ((pre_nx & pre_mask) == '0);

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pre_q <= '0;
    else if (!pre_run)
      pre_q <= '0;
    else if (i_cnt_tick)
      pre_q <= pre_nx;
  end

  // Disabling correction lets a started interval finish its cycles
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cal_span_q <= '0;
      cal_left_q <= 7'h00;
    end
    else if (pre_run && i_cnt_tick)
    begin
      if (cal_span_q == CAL_W'(CAL_SPAN - 1))
      begin
        cal_span_q <= '0;
        cal_left_q <= ctrl_act_q.drift_fix_enable ? trim_q[6:0] : 7'h00;
      end
      else
      begin
        cal_span_q <= cal_span_q + CAL_W'(1);
        if (cal_left_q != 7'h00)
          cal_left_q <= cal_left_q - 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // wrap at limit
  assign wrap_hit = cnt_run && pre_pulse && !sy_apply[SY_CNT] &&
                    (cnt_q == lim_act_q);
  assign cnt_nx = wrap_hit ? 16'h0000 : cnt_q + 16'h0001;
  assign match_hit = cnt_run && pre_pulse && !sy_apply[SY_CNT] &&
                     (cnt_nx == mat_act_q);

  // steps only on counter clock enables
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cnt_q <= RST_COUNT;
    else if (sy_apply[SY_CNT])
      cnt_q <= cnt_new_q;
    else if (cnt_run && pre_pulse)
      cnt_q <= cnt_nx;
  end

  // ----------------------------------------------------------------
  // Interrupt flags and request
  // ----------------------------------------------------------------
  // write one clears, set wins
  always_comb
  begin
    flags_d = flags_q;
    if (wr_en && aw_idx_q == IDX_IFLG)
      flags_d = flags_d & ~wbyte_q[1:0];
    flags_d[FLG_WRAP] = flags_d[FLG_WRAP] | wrap_hit;
    flags_d[FLG_MATCH] = flags_d[FLG_MATCH] | match_hit;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      flags_q <= 2'h0;
      o_irq <= 1'b0;
      o_wrap_evt <= 1'b0;
      o_match_evt <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      o_irq <= |(flags_d & ien_q);
      o_wrap_evt <= wrap_hit;
      o_match_evt <= match_hit;
    end
  end

endmodule : rtcr_top

// ### verif/rtcr_chk.sv
// Port-level timing checks of the counter register block.
// Assumes it is bound into rtcr_top and sees only its ports.
`timescale 1ns/1ps
module rtcr_chk (
  input wire logic i_mclk,        // Bus clock
  input wire logic i_rst_b,       // Reset, active low
  input wire logic i_cnt_tick,    // Counter clock enable
  input wire logic i_awvalid,     // Write address valid
  input wire logic o_awready,     // Write address ready
  input wire logic i_wvalid,      // Write data valid
  input wire logic o_wready,      // Write data ready
  input wire logic o_bvalid,      // Write response valid
  input wire logic i_bready,      // Write response ready
  input wire logic i_arvalid,     // Read address valid
  input wire logic o_arready,     // Read address ready
  input wire logic o_rvalid,      // Read data valid
  input wire logic [31:0] o_rdata, // Read data
  input wire logic o_irq,         // Interrupt level
  input wire logic o_wrap_evt,    // Wrap pulse
  input wire logic o_match_evt    // Match pulse
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  property p_b_ans;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write not answered");
  property p_b_one;
    o_bvalid && i_bready |=> !o_bvalid;
  endproperty
  a_b_one: assert property (p_b_one) else $error("write answered twice");
  property p_rd_ans;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_ar_busy;
    o_rvalid |-> !o_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read overlap");
  property p_rdata;
    o_rvalid |-> o_rdata[31:8] == 24'h000000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read upper bits set");
  property p_wrap_tick;
    o_wrap_evt |-> $past(i_cnt_tick);
  endproperty
  a_wrap_tick: assert property (p_wrap_tick) else $error("wrap no tick");
  property p_match_tick;
    o_match_evt |-> $past(i_cnt_tick);
  endproperty
  a_match_tick: assert property (p_match_tick) else $error("match no tick");
  property p_irq_rise;
    $rose(o_irq) |-> o_wrap_evt || o_match_evt || $past(o_bvalid);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq no cause");
  property p_irq_fall;
    $fell(o_irq) |-> o_bvalid || $past(o_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule : rtcr_chk

bind rtcr_top rtcr_chk u_chk (.*);

// ### verif/rtcr_top_tb.sv
// Self-checking bench of the counter register block.
// Assumes rtcr_top with a short drift span; ticks driven by the bench.
`timescale 1ns/1ps
module rtcr_top_tb;
  import rtcr_pkg::*;
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_cnt_tick = 1'b0, i_standby = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic [6:0] i_awaddr = 7'h00, i_araddr = 7'h00;
  logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_irq, o_wrap_evt, o_match_evt;
  logic [1:0] o_bresp, o_rresp, o_clk_source;
  logic [31:0] o_rdata;
  int fail_count = 0, checked = 0;
  logic [31:0] rnd = 32'hCB10A530;
  localparam logic [4:0] RI [7] = '{IDX_CTRL, IDX_STAT, IDX_IEN, IDX_IFLG,
    IDX_LATCH, IDX_LIM_L, IDX_LIM_H};
  localparam logic [7:0] RE [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hFF};
  localparam logic [4:0] SI [5] = '{IDX_CTRL, IDX_CNT_H, IDX_LIM_H,
    IDX_MAT_H, IDX_TCTL};
  localparam logic [4:0] EI [6] = '{IDX_LIM_L, IDX_LIM_H, IDX_MAT_L,
    IDX_MAT_H, IDX_IEN, IDX_CTRL};
  localparam logic [7:0] ED [6] = '{8'h03, 8'h00, 8'h02, 8'h00, 8'h03,
    8'h01};
  localparam logic [4:0] QI [4] = '{IDX_IFLG, IDX_IEN, IDX_IEN, IDX_IFLG};
  localparam logic [7:0] QD [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
  localparam logic [3:0] QE = 4'h5;

  always #25 i_mclk = ~i_mclk;

  rtcr_top #(.CAL_SPAN(256)) dut (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [6:0] ba(input logic [4:0] x);
    return {x, 2'b00};
  endfunction : ba

  // One step per full divider window while running
  function automatic logic [15:0] steps(input logic [7:0] c, input logic s);
    return (c[0] && (c[7] || !s)) ? 16'h0001 : 16'h0000;
  endfunction : steps

  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Ready sampled at negedge, so the release edge is race free
  task automatic acc(input logic we, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge i_mclk);
    if (we)
    begin
      i_awaddr <= a;
      i_wdata <= {24'h000000, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
    end
    else
    begin
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
    end
    for (int n = 0; n < 40; n++)
    begin
      @(negedge i_mclk);
      ta = we ? o_awready : o_arready;
      tw = o_wready;
      tb = we ? o_bvalid : o_rvalid;
      r = we ? o_bresp : o_rresp;
      q = o_rdata[7:0];
      @(posedge i_mclk);
      if (ta)
      begin
        i_awvalid <= 1'b0;
        i_arvalid <= 1'b0;
      end
      if (tw)
        i_wvalid <= 1'b0;
      if (tb)
      begin
        i_bready <= 1'b0;
        i_rready <= 1'b0;
        return;
      end
    end
    fail_count++;
    stop_test();
  endtask : acc

  task automatic tk(input int n);
    i_cnt_tick <= 1'b1;
    repeat (n) @(posedge i_mclk);
    i_cnt_tick <= 1'b0;
  endtask : tk

  task automatic rc(output logic [15:0] v);
    logic [7:0] l, h;
    logic [1:0] r;
    acc(1'b0, ba(IDX_CNT_L), 8'h00, l, r);
    acc(1'b0, ba(IDX_CNT_H), 8'h00, h, r);
    v = {h, l};
  endtask : rc

  initial
  begin
    logic [7:0] q, c;
    logic [1:0] r;
    logic [15:0] v0, v1;
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      acc(1'b0, ba(RI[i]), 8'h00, q, r);
      chk(16'(q), 16'(RE[i]));
    end
    for (int i = 0; i < 2; i++)
    begin
      acc(1'b1, i ? 7'h38 : 7'h01, 8'h55, q, r);
      chk(16'(r), 16'(RESP_SLVERR));
      acc(1'b0, i ? 7'h38 : 7'h01, 8'h00, q, r);
      chk(16'({r, q}), 16'({RESP_SLVERR, 8'h00}));
    end
    rnd = lfsr(rnd);
    acc(1'b1, ba(IDX_LATCH), rnd[7:0], q, r);
    acc(1'b0, ba(IDX_LATCH), 8'h00, q, r);
    chk(16'(q), 16'(rnd[7:0]));
    acc(1'b1, ba(IDX_LATCH), 8'h00, q, r);
    acc(1'b1, ba(IDX_SRC), rnd[15:8], q, r);
    @(negedge i_mclk);
    chk(16'(o_clk_source), 16'(rnd[9:8]));
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b1, ba(SI[i]), 8'h00, q, r);
      acc(1'b0, ba(i == 4 ? IDX_TSTAT : IDX_STAT), 8'h00, q, r);
      chk(16'(q), 16'(8'h01 << (i % 4)));
      tk(2);
      acc(1'b0, ba(i == 4 ? IDX_TSTAT : IDX_STAT), 8'h00, q, r);
      chk(16'(q), 16'h0000);
    end
    for (int i = 0; i < 6; i++)
      acc(1'b1, ba(EI[i]), ED[i], q, r);
    acc(1'b0, ba(IDX_LIM_H), 8'h00, q, r);
    chk(16'(q), 16'(ED[2]));
    tk(10);
    acc(1'b0, ba(IDX_IFLG), 8'h00, q, r);
    @(negedge i_mclk);
    chk(16'({o_irq, q}), 16'h0103);
    rc(v0);
    tk(9);
    rc(v1);
    chk(v1, (v0 + 16'h0001) % 16'h0004);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, ba(QI[i]), QD[i], q, r);
      @(negedge i_mclk);
      chk(16'(o_irq), 16'(QE[i]));
    end
    acc(1'b1, ba(IDX_IEN), 8'h01, q, r);
    tk(8);
    acc(1'b0, ba(IDX_IFLG), 8'h00, q, r);
    @(negedge i_mclk);
    chk(16'({o_irq, q}), 16'h0103);
    acc(1'b1, ba(IDX_LIM_L), 8'hFF, q, r);
    acc(1'b1, ba(IDX_LIM_H), 8'hFF, q, r);
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      c = {rnd[7], 4'(i), rnd[2], 1'b0, rnd[3]};
      i_standby <= rnd[8];
      acc(1'b1, ba(IDX_CTRL), c, q, r);
      tk(2);
      acc(1'b0, ba(IDX_CTRL), 8'h00, q, r);
      chk(16'(q), 16'(c));
      rc(v0);
      tk(1 << i);
      rc(v1);
      chk(v1 - v0, steps(c, rnd[8]));
    end
    stop_test();
  end
endmodule : rtcr_top_tb
